/* core/dac_pwm_core.v */
`include "dac_consts.vh"

// Converter core: two channels share one slot counter and one shutdown path
module dac_pwm_core #(
  // Timing in master clocks; short counts may be given to shorten simulation
  parameter [20:0] DEB_CYCLES           = `DEB_COUNT,
  parameter [25:0] REPEAT_DELAY_CYCLES  = `REPEAT_DELAY_COUNT,
  parameter [25:0] REPEAT_PERIOD_CYCLES = `REPEAT_PERIOD_COUNT
) (
  // Clock and reset
  input  wire mclk_in,
  input  wire rst_in,
  // Step inputs and their floating senses
  input  wire chan1_step_input_in,
  input  wire chan1_step_float_in,
  input  wire chan2_step_input_in,
  input  wire chan2_step_float_in,
  // Shutdown, active low
  input  wire sleep_n_in,
  // PWM outputs with output enables
  output reg  chan1_pulse_out,
  output reg  chan1_pulse_oe_out,
  output reg  chan2_pulse_out,
  output reg  chan2_pulse_oe_out,
  // Selected interface mode
  output reg  pushbutton_mode_out
);

  // Shared shutdown, mode and slot state
  reg        sleep_meta;
  reg        awake;
  reg  [1:0] settle_cnt;
  reg        mode_valid;
  reg  [8:0] slot_div;
  reg  [5:0] slot_idx;

  // Pins gathered into per-channel vectors, channel 1 in the low bits
  wire [1:0]  step_lvl;
  wire [1:0]  step_flt;
  wire [1:0]  lvl_sync;
  wire [1:0]  flt_sync;
  wire [11:0] code;
  wire        step_ok;

  assign step_lvl = {chan2_step_input_in, chan1_step_input_in};
  assign step_flt = {chan2_step_float_in, chan1_step_float_in};
  assign step_ok  = mode_valid & awake;

  // Saturating step in pushbutton mode, wrapping increment in pulse mode
  // Down steps never wrap: pulse mode only ever counts up
  function [5:0] step_code;
    input [5:0] c;
    input       wrap;
    input       up;
    begin
      if (up) begin
        if (c == `CODE_MAX && !wrap) begin
          step_code = c;
        end else begin
          step_code = c + 6'h01;
        end
      end else begin
        if (c == `CODE_MIN) begin
          step_code = c;
        end else begin
          step_code = c - 6'h01;
        end
      end
    end
  endfunction

  // Slot compare shared by both channels; code zero is never high, 63 is high 63 of 64 slots
  function duty_high;
    input [5:0] idx;
    input [5:0] c;
    begin
      duty_high = (idx < c);
    end
  endfunction

  // Shutdown pin synchroniser
  // The pins release three edges after the pin falls, two of them spent in synchronising
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sleep_meta <= 1'b0;
      awake      <= 1'b0;
    end else begin
      sleep_meta <= sleep_n_in;
      awake      <= sleep_meta;
    end
  end

  // Mode is sampled once, after the synchronisers have filled, and held until the next reset
  // Steps are refused until then, so a pin still settling cannot count
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_cnt          <= 2'h0;
      mode_valid          <= 1'b0;
      pushbutton_mode_out <= 1'b0;
    end else if (!mode_valid) begin
      if (settle_cnt == `SETTLE_CYCLES) begin
        mode_valid          <= 1'b1;
        pushbutton_mode_out <= flt_sync[0] & flt_sync[1];
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // Free-running slot counter; parked while asleep so a wake starts a clean period
  // 312 clocks a slot and 64 slots give a period near 5 kHz at 100 MHz
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      slot_div <= 9'd0;
      slot_idx <= 6'h00;
    end else if (!awake) begin
      slot_div <= 9'd0;
      slot_idx <= 6'h00;
    end else if (slot_div == `SLOT_CYCLES - 9'd1) begin
      slot_div <= 9'd0;
      slot_idx <= slot_idx + 6'h01;
    end else begin
      slot_div <= slot_div + 9'd1;
    end
  end

  // Output drivers: compare against the code, release the pins in shutdown
  // The level is forced low as well so a released pin never shows a stale high
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      chan1_pulse_out    <= 1'b0;
      chan2_pulse_out    <= 1'b0;
      chan1_pulse_oe_out <= 1'b0;
      chan2_pulse_oe_out <= 1'b0;
    end else begin
      chan1_pulse_out    <= awake & duty_high(slot_idx, code[5:0]);
      chan2_pulse_out    <= awake & duty_high(slot_idx, code[11:6]);
      chan1_pulse_oe_out <= awake;
      chan2_pulse_oe_out <= awake;
    end
  end

  // One copy of the step logic per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      reg        prev_lvl;
      reg  [1:0] prev_press;
      reg  [25:0] rep_timer;
      reg  [5:0] code_q;
      wire [1:0] pr;
      wire       pulse_edge;
      wire       new_press;

      // Edge and new-press detectors against last cycle's history
      assign pulse_edge = lvl_sync[ch] & ~prev_lvl;
      assign new_press  = pr[1] & (pr != prev_press);
      assign code[6*ch+5:6*ch] = code_q;

      // Each channel owns its pin conditioning
      step_sense #(
        .DEB_CYCLES (DEB_CYCLES)
      ) u_sense (
        .mclk_in        (mclk_in),
        .rst_in         (rst_in),
        .level_in       (step_lvl[ch]),
        .float_in       (step_flt[ch]),
        .level_sync_out (lvl_sync[ch]),
        .float_sync_out (flt_sync[ch]),
        .press_out      (pr)
      );

      // Code register and repeat timer; history tracks even while asleep
      // so a level change during shutdown cannot fire a step on wake
      always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          prev_lvl   <= 1'b0;
          prev_press <= 2'b00;
          rep_timer  <= 26'd0;
          code_q     <= `CODE_MID;
        end else begin
          prev_lvl   <= lvl_sync[ch];
          prev_press <= pr;
          if (!step_ok) begin
            rep_timer <= REPEAT_DELAY_CYCLES - 26'd1;
          end else if (!pushbutton_mode_out) begin
            // Pulse mode counts rising edges only
            if (pulse_edge) begin
              code_q <= step_code(code_q, 1'b1, 1'b1);
            end
          end else if (new_press) begin
            // First step lands on the edge after the press is debounced
            code_q    <= step_code(code_q, 1'b0, pr[0]);
            rep_timer <= REPEAT_DELAY_CYCLES - 26'd1;
          end else if (pr[1]) begin
            // Held press: wait out the delay, then step at the repeat rate
            if (rep_timer == 26'd0) begin
              code_q    <= step_code(code_q, 1'b0, pr[0]);
              rep_timer <= REPEAT_PERIOD_CYCLES - 26'd1;
            end else begin
              rep_timer <= rep_timer - 26'd1;
            end
          end
        end
      end
    end
  endgenerate

endmodule

/* shared/dac_consts.vh */
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// Channel code width and landmark codes
`define CODE_W            6
`define CODE_MIN          6'h00
`define CODE_MID          6'h20
`define CODE_MAX          6'h3f

// Master clock
`define CLK_HZ            100000000
`define CLK_PERIOD_NS     10

// Pushbutton timing: debounce 12.8 ms, repeat delay 410 ms, repeat rate 19.5 Hz (in tenths of Hz)
`define DEB_TIME_NS       12800000
`define REPEAT_DELAY_NS   410000000
`define REPEAT_FREQ_DHZ   195

// The same pushbutton timing as master-clock counts: debounce, delay, one repeat period rounded down
`define DEB_COUNT           21'd1280000
`define REPEAT_DELAY_COUNT  26'd41000000
`define REPEAT_PERIOD_COUNT 26'd5128205

// One PWM slot for a 5 kHz period of 64 slots
`define SLOT_TIME_NS      3125
`define SLOT_CYCLES       9'd312

// Synchroniser settle cycles before the mode is sampled after reset
`define SETTLE_CYCLES     2'h3

`endif

/* core/step_sense.v */
`include "dac_consts.vh"

module step_sense #(
  parameter [20:0] DEB_CYCLES = `DEB_COUNT
) (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       rst_in,
  // Raw pin and its floating sense
  input  wire       level_in,
  input  wire       float_in,
  // Synchronised and debounced views
  output reg        level_sync_out,
  output reg        float_sync_out,
  output reg  [1:0] press_out
);

  reg        level_meta;
  reg        float_meta;
  reg  [1:0] cand_q;
  reg  [20:0] stable_cnt;
  wire [1:0] cand;

  // Two-stage synchronisers; the first stage feeds nothing else
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      level_meta     <= 1'b0;
      level_sync_out <= 1'b0;
      float_meta     <= 1'b0;
      float_sync_out <= 1'b0;
    end else begin
      level_meta     <= level_in;
      level_sync_out <= level_meta;
      float_meta     <= float_in;
      float_sync_out <= float_meta;
    end
  end

  // Press code: 00 released, 10 held low, 11 held high
  assign cand = float_sync_out ? 2'b00 : {1'b1, level_sync_out};

  // Any change restarts the stability count, so bounces never reach the output
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cand_q     <= 2'b00;
      stable_cnt <= 21'd0;
      press_out  <= 2'b00;
    end else if (cand != cand_q) begin
      cand_q     <= cand;
      stable_cnt <= 21'd0;
    end else if (stable_cnt == DEB_CYCLES - 21'd1) begin
      press_out  <= cand_q;
    end else begin
      stable_cnt <= stable_cnt + 21'd1;
    end
  end

endmodule

/* tb/dac_pwm_checker.sv */
module dac_pwm_checker #(
  parameter int DEB_CYCLES = 8
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Step pins and shutdown
  input wire chan1_step_input_in,
  input wire chan1_step_float_in,
  input wire chan2_step_input_in,
  input wire chan2_step_float_in,
  input wire sleep_n_in,
  // Outputs
  input wire chan1_pulse_out,
  input wire chan1_pulse_oe_out,
  input wire chan2_pulse_out,
  input wire chan2_pulse_oe_out,
  input wire pushbutton_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOT = 312;
  logic [14:0] run1;
  logic [14:0] run2;
  logic [23:0] quiet;
  logic [3:0]  age;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Any step activity restarts quiet, since a code change may cut a slot short
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      run1  <= 15'h0000;
      run2  <= 15'h0000;
      quiet <= 24'h000000;
      age   <= 4'h0;
    end else begin
      run1 <= chan1_pulse_out ? run1 + 15'h0001 : 15'h0000;
      run2 <= chan2_pulse_out ? run2 + 15'h0001 : 15'h0000;
      age  <= (age == 4'hf) ? age : age + 4'h1;
      if ($changed(chan1_step_float_in) || $changed(chan2_step_float_in) ||
          (!chan1_step_float_in && ($changed(chan1_step_input_in) || pushbutton_mode_out)) ||
          (!chan2_step_float_in && ($changed(chan2_step_input_in) || pushbutton_mode_out)))
        quiet <= 24'h000000;
      else if (quiet != 24'hffffff)
        quiet <= quiet + 24'h000001;
    end
  end
  property p_sleep1; !sleep_n_in [*4] |-> !chan1_pulse_oe_out; endproperty
  a_sleep1: assert property (p_sleep1) else $error("ch1 driven asleep");
  property p_sleep2; !sleep_n_in [*4] |-> !chan2_pulse_oe_out; endproperty
  a_sleep2: assert property (p_sleep2) else $error("ch2 driven asleep");
  property p_wake; sleep_n_in [*5] |-> chan1_pulse_oe_out && chan2_pulse_oe_out; endproperty
  a_wake: assert property (p_wake) else $error("no drive awake");
  property p_idle; (chan1_pulse_oe_out || !chan1_pulse_out) && (chan2_pulse_oe_out || !chan2_pulse_out); endproperty
  a_idle: assert property (p_idle) else $error("pulse without enable");
  property p_run1; $fell(chan1_pulse_out) && chan1_pulse_oe_out && quiet > run1 + DEB_CYCLES + 8
    |-> run1 % SLOT == 0 && run1 <= 63 * SLOT; endproperty
  a_run1: assert property (p_run1) else $error("ch1 bad high time");
  property p_run2; $fell(chan2_pulse_out) && chan2_pulse_oe_out && quiet > run2 + DEB_CYCLES + 8
    |-> run2 % SLOT == 0 && run2 <= 63 * SLOT; endproperty
  a_run2: assert property (p_run2) else $error("ch2 bad high time");
  property p_mode; age == 4'h6 |-> pushbutton_mode_out == (chan1_step_float_in && chan2_step_float_in); endproperty
  a_mode: assert property (p_mode) else $error("wrong mode");
  property p_keep; age > 4'h7 |-> $stable(pushbutton_mode_out); endproperty
  a_keep: assert property (p_keep) else $error("mode changed");
endmodule

/* tb/step_partner.sv */
module step_partner (
  // Clock
  input  wire  mclk_in,
  // Pin level and floating sense
  output logic level_out = 1'b0,
  output logic float_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic loose = 1'b0;
  // A released pin has no level, so it wanders after each rising edge
  always @(posedge mclk_in) begin
    if (float_out && loose)
      level_out <= ~level_out;
  end
  // Set the pin and hold it n more cycles
  task automatic drive(input logic f, input logic lvl, input int n);
    @(negedge mclk_in);
    loose     = 1'b0;
    float_out = f;
    level_out = lvl;
    repeat (n) @(negedge mclk_in);
  endtask
  // Press then release; too short a press is a bounce
  // The release is held past the debounce time so the next press counts as new
  task automatic press(input logic dir, input int n);
    drive(1'b0, dir, n);
    drive(1'b1, ~dir, 16);
    loose = 1'b1;
  endtask
  // Count pulses, each level held 3 cycles
  task automatic pulses(input int n);
    repeat (n) begin
      drive(1'b0, 1'b1, 2);
      drive(1'b0, 1'b0, 2);
    end
  endtask
endmodule

/* tb/test_dual_six_bit_pwm_dac_control.sv */
`include "dac_consts.vh"
module test_dual_six_bit_pwm_dac_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in    = 1'b0;
  logic        rst_in     = 1'b1;
  logic        sleep_n_in = 1'b1;
  logic [31:0] rnd        = 32'h0443;
  wire         lvl1, flt1, lvl2, flt2, p1, oe1, p2, oe2, mode;
  int          n_fail, comparisons, code1, code2;
  always #5 mclk_in = ~mclk_in;
  // Short pushbutton timing keeps the run brief
  dac_pwm_core #(.DEB_CYCLES(21'd8), .REPEAT_DELAY_CYCLES(26'd40), .REPEAT_PERIOD_CYCLES(26'd16)) dac_pwm_core_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .chan1_step_input_in(lvl1), .chan1_step_float_in(flt1),
    .chan2_step_input_in(lvl2), .chan2_step_float_in(flt2), .sleep_n_in(sleep_n_in),
    .chan1_pulse_out(p1), .chan1_pulse_oe_out(oe1), .chan2_pulse_out(p2), .chan2_pulse_oe_out(oe2),
    .pushbutton_mode_out(mode));
  step_partner chan1_partner (.mclk_in(mclk_in), .level_out(lvl1), .float_out(flt1));
  step_partner chan2_partner (.mclk_in(mclk_in), .level_out(lvl2), .float_out(flt2));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Mode pins are set before reset and held through capture
  task automatic restart(input logic f);
    chan1_partner.drive(f, 1'b0, 0);
    chan2_partner.drive(f, 1'b0, 0);
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    code1 = 32;
    code2 = 32;
    cmp({15'h0000, mode}, {15'h0000, f});
  endtask
  // High cycles over one whole period are phase independent
  task automatic measure();
    logic [15:0] h1, h2;
    int          i;
    h1 = 16'h0000;
    h2 = 16'h0000;
    for (i = 0; i < 50 && {oe1, oe2} !== 2'b11; i++)
      @(negedge mclk_in);
    if ({oe1, oe2} !== 2'b11) begin
      n_fail++;
      give_verdict();
    end
    repeat (30) @(negedge mclk_in);
    repeat (64 * `SLOT_CYCLES) begin
      @(negedge mclk_in);
      h1 += {15'h0000, p1};
      h2 += {15'h0000, p2};
    end
    cmp(h1, 16'(code1 * `SLOT_CYCLES));
    cmp(h2, 16'(code2 * `SLOT_CYCLES));
  endtask
  initial begin
    n_fail = 0;
    comparisons = 0;
    restart(1'b0);
    measure();
    chan1_partner.pulses(31);
    code1 = (code1 + 31) % 64;
    rnd = lfsr(rnd);
    chan2_partner.pulses(32 + rnd[4:0]);
    code2 = (code2 + 32 + rnd[4:0]) % 64;
    measure();
    sleep_n_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    cmp({12'h000, oe1, oe2, p1, p2}, 16'h0000);
    chan2_partner.pulses(5);
    sleep_n_in = 1'b1;
    measure();
    restart(1'b1);
    // One short press steps once; a long one repeats into the saturation limit
    chan1_partner.press(1'b1, 30);
    chan1_partner.press(1'b1, 1000);
    chan2_partner.press(1'b0, 1000);
    chan2_partner.press(1'b1, 30);
    chan2_partner.press(1'b0, 3);
    code1 = 63;
    code2 = 1;
    measure();
    give_verdict();
  end
endmodule
bind dac_pwm_core dac_pwm_checker #(.DEB_CYCLES(DEB_CYCLES)) dac_pwm_checker_i (
  .mclk_in(mclk_in), .rst_in(rst_in), .chan1_step_input_in(chan1_step_input_in),
  .chan1_step_float_in(chan1_step_float_in), .chan2_step_input_in(chan2_step_input_in),
  .chan2_step_float_in(chan2_step_float_in), .sleep_n_in(sleep_n_in),
  .chan1_pulse_out(chan1_pulse_out), .chan1_pulse_oe_out(chan1_pulse_oe_out),
  .chan2_pulse_out(chan2_pulse_out), .chan2_pulse_oe_out(chan2_pulse_oe_out),
  .pushbutton_mode_out(pushbutton_mode_out));
